/* rtl/adc_result_defines.vh */
// Select codes, field layout and reset values of the per-port result registers
`ifndef ADC_RESULT_DEFINES_VH
`define ADC_RESULT_DEFINES_VH

// ****************************************************************
// Register select codes
// ****************************************************************
`define SEL_PORT_VOLTAGE_LOW     4'h8
`define SEL_PORT_VOLTAGE_HIGH    4'h9
`define SEL_PORT_CURRENT_LOW     4'hA
`define SEL_PORT_CURRENT_HIGH    4'hB
`define SEL_DIE_TEMPERATURE_LOW  4'hC
`define SEL_DIE_TEMPERATURE_HIGH 4'hD

// ****************************************************************
// Field layout
// ****************************************************************
`define RESULT_W                 15
`define LOW_FIELD_MSB            7
`define LOW_FIELD_LSB            0
`define HIGH_FIELD_MSB           14
`define HIGH_FIELD_LSB           8
`define DONE_FLAG_BIT            7

// ****************************************************************
// Reset values
// ****************************************************************
`define RESULT_RST               15'h0000
`define DONE_FLAG_RST            1'b0
`define BUSY_RST                 1'b0
`define READ_DATA_RST            8'h00
`define VALID_RST                1'b0
`define HIT_RST                  1'b0
`define UNMAPPED_DATA            8'h00

`endif

/* rtl/adc_result_slot.v */
// One conversion result holder: 15-bit value, completion flag and busy state
`timescale 1ns/1ps
`include "adc_result_defines.vh"

module adc_result_slot #(
    parameter W = `RESULT_W
) (
    // Clock and reset
    input  wire         mclk,
    input  wire         nrst,
    // Conversion events
    input  wire         conv_start,
    input  wire         conv_done,
    input  wire [W-1:0] conv_result,
    // Held state
    output reg  [W-1:0] result_ff,
    output reg          done_flag_ff,
    output reg          busy_ff
);

    reg [W-1:0] nxt_result;
    reg         nxt_done_flag;
    reg         nxt_busy;

    // ****************************************************************
    // Flag and result update
    // ****************************************************************
    // Done beats start in one cycle so a finished conversion is never lost
    always @* begin
        nxt_result    = result_ff;
        nxt_done_flag = done_flag_ff;
        nxt_busy      = busy_ff;
        if (conv_done) begin
            nxt_result    = conv_result;
            nxt_done_flag = 1'b1;
            nxt_busy      = 1'b0;
        end else if (conv_start) begin
            nxt_done_flag = 1'b0;
            nxt_busy      = 1'b1;
        end
    end

    always @(posedge mclk) begin
        if (!nrst) begin
            result_ff    <= `RESULT_RST;
            done_flag_ff <= `DONE_FLAG_RST;
            busy_ff      <= `BUSY_RST;
        end else begin
            result_ff    <= nxt_result;
            done_flag_ff <= nxt_done_flag;
            busy_ff      <= nxt_busy;
        end
    end

endmodule

/* rtl/port_adc_result_registers.v */
// Per-port voltage, current and temperature result registers with read port
//
// Contract
// - Select code 1000 of each port returns voltage result bits 7 to 0.
// - Select code 1001 of each port returns voltage result bits 14 to 8 in D6 to D0.
// - Voltage done flag in D7 of 1001 clears at conversion start, sets at end, resets to 0.
// - Select code 1010 of each port returns current result bits 7 to 0.
// - Select code 1011 of each port returns current result bits 14 to 8 in D6 to D0.
// - Current done flag in D7 of 1011 is low during conversion, high after, resets to 0.
// - Select code 1100 of each port returns temperature result bits 7 to 0.
// - Select code 1101 of each port returns temperature result bits 14 to 8 in D6 to D0.
// - Temperature done flag in D7 of 1101 clears at start, sets at end, resets to 0.
`timescale 1ns/1ps
`include "adc_result_defines.vh"

module port_adc_result_registers #(
    parameter NPORT  = 4,
    parameter PORT_W = 2
) (
    // Clock and reset
    input  wire                       mclk,
    input  wire                       nrst,
    // Voltage conversion events, one lane per port
    input  wire [NPORT-1:0]           volt_start,
    input  wire [NPORT-1:0]           volt_done,
    input  wire [NPORT*`RESULT_W-1:0] volt_result,
    // Current conversion events, one lane per port
    input  wire [NPORT-1:0]           cur_start,
    input  wire [NPORT-1:0]           cur_done,
    input  wire [NPORT*`RESULT_W-1:0] cur_result,
    // Temperature conversion events, one lane per port
    input  wire [NPORT-1:0]           temp_start,
    input  wire [NPORT-1:0]           temp_done,
    input  wire [NPORT*`RESULT_W-1:0] temp_result,
    // Register read port from the serial management interface
    input  wire                       rd_en,
    input  wire [PORT_W-1:0]          rd_port,
    input  wire [3:0]                 rd_sel,
    output reg  [7:0]                 rd_data_ff,
    output reg                        rd_valid_ff,
    output reg                        rd_hit_ff,
    // Per-port status
    output wire [NPORT-1:0]           volt_ready,
    output wire [NPORT-1:0]           cur_ready,
    output wire [NPORT-1:0]           temp_ready,
    output wire [NPORT-1:0]           meas_active
);

    // ****************************************************************
    // Held results
    // ****************************************************************
    wire [NPORT*`RESULT_W-1:0] volt_word;
    wire [NPORT*`RESULT_W-1:0] cur_word;
    wire [NPORT*`RESULT_W-1:0] temp_word;
    wire [NPORT-1:0]           volt_busy;
    wire [NPORT-1:0]           cur_busy;
    wire [NPORT-1:0]           temp_busy;

    genvar p;
    generate
        for (p = 0; p < NPORT; p = p + 1) begin : g_port
            adc_result_slot #(
                .W (`RESULT_W)
            ) u_volt (
                .mclk         (mclk),
                .nrst         (nrst),
                .conv_start   (volt_start[p]),
                .conv_done    (volt_done[p]),
                .conv_result  (volt_result[p*`RESULT_W +: `RESULT_W]),
                .result_ff    (volt_word[p*`RESULT_W +: `RESULT_W]),
                .done_flag_ff (volt_ready[p]),
                .busy_ff      (volt_busy[p])
            );

            adc_result_slot #(
                .W (`RESULT_W)
            ) u_cur (
                .mclk         (mclk),
                .nrst         (nrst),
                .conv_start   (cur_start[p]),
                .conv_done    (cur_done[p]),
                .conv_result  (cur_result[p*`RESULT_W +: `RESULT_W]),
                .result_ff    (cur_word[p*`RESULT_W +: `RESULT_W]),
                .done_flag_ff (cur_ready[p]),
                .busy_ff      (cur_busy[p])
            );

            adc_result_slot #(
                .W (`RESULT_W)
            ) u_temp (
                .mclk         (mclk),
                .nrst         (nrst),
                .conv_start   (temp_start[p]),
                .conv_done    (temp_done[p]),
                .conv_result  (temp_result[p*`RESULT_W +: `RESULT_W]),
                .result_ff    (temp_word[p*`RESULT_W +: `RESULT_W]),
                .done_flag_ff (temp_ready[p]),
                .busy_ff      (temp_busy[p])
            );
        end
    endgenerate

    // Any conversion in flight on a port
    assign meas_active = volt_busy | cur_busy | temp_busy;

    // ****************************************************************
    // Port selection
    // ****************************************************************
    // Out-of-range port numbers pick nothing and read as unmapped
    reg [`RESULT_W-1:0] sel_volt;
    reg [`RESULT_W-1:0] sel_cur;
    reg [`RESULT_W-1:0] sel_temp;
    reg                 sel_volt_rdy;
    reg                 sel_cur_rdy;
    reg                 sel_temp_rdy;
    reg                 port_ok;
    integer             i;

    always @* begin
        sel_volt     = `RESULT_RST;
        sel_cur      = `RESULT_RST;
        sel_temp     = `RESULT_RST;
        sel_volt_rdy = `DONE_FLAG_RST;
        sel_cur_rdy  = `DONE_FLAG_RST;
        sel_temp_rdy = `DONE_FLAG_RST;
        port_ok      = 1'b0;
        for (i = 0; i < NPORT; i = i + 1) begin
            if (rd_port == i[PORT_W-1:0]) begin
                sel_volt     = volt_word[i*`RESULT_W +: `RESULT_W];
                sel_cur      = cur_word[i*`RESULT_W +: `RESULT_W];
                sel_temp     = temp_word[i*`RESULT_W +: `RESULT_W];
                sel_volt_rdy = volt_ready[i];
                sel_cur_rdy  = cur_ready[i];
                sel_temp_rdy = temp_ready[i];
                port_ok      = 1'b1;
            end
        end
    end

    // ****************************************************************
    // Mapped select codes
    // ****************************************************************
    // Hit decoded apart from the data mux; codes E and F stay unmapped
    reg sel_mapped;

    always @* begin
        case (rd_sel)
            `SEL_PORT_VOLTAGE_LOW:     sel_mapped = 1'b1;
            `SEL_PORT_VOLTAGE_HIGH:    sel_mapped = 1'b1;
            `SEL_PORT_CURRENT_LOW:     sel_mapped = 1'b1;
            `SEL_PORT_CURRENT_HIGH:    sel_mapped = 1'b1;
            `SEL_DIE_TEMPERATURE_LOW:  sel_mapped = 1'b1;
            `SEL_DIE_TEMPERATURE_HIGH: sel_mapped = 1'b1;
            default:                   sel_mapped = 1'b0;
        endcase
    end

    // ****************************************************************
    // Register select decode
    // ****************************************************************
    // Reads have no side effect; flag stays set until the next start
    reg [7:0] nxt_rd_data;
    reg       nxt_rd_hit;

    always @* begin
        nxt_rd_hit  = port_ok & sel_mapped;
        nxt_rd_data = `UNMAPPED_DATA;
        case (rd_sel)
            `SEL_PORT_VOLTAGE_LOW: begin
                nxt_rd_data = sel_volt[`LOW_FIELD_MSB:`LOW_FIELD_LSB];
            end
            `SEL_PORT_VOLTAGE_HIGH: begin
                nxt_rd_data = {sel_volt_rdy,
                               sel_volt[`HIGH_FIELD_MSB:`HIGH_FIELD_LSB]};
            end
            `SEL_PORT_CURRENT_LOW: begin
                nxt_rd_data = sel_cur[`LOW_FIELD_MSB:`LOW_FIELD_LSB];
            end
            `SEL_PORT_CURRENT_HIGH: begin
                nxt_rd_data = {sel_cur_rdy,
                               sel_cur[`HIGH_FIELD_MSB:`HIGH_FIELD_LSB]};
            end
            `SEL_DIE_TEMPERATURE_LOW: begin
                nxt_rd_data = sel_temp[`LOW_FIELD_MSB:`LOW_FIELD_LSB];
            end
            `SEL_DIE_TEMPERATURE_HIGH: begin
                nxt_rd_data = {sel_temp_rdy,
                               sel_temp[`HIGH_FIELD_MSB:`HIGH_FIELD_LSB]};
            end
            default: begin
                nxt_rd_data = `UNMAPPED_DATA;
            end
        endcase
        if (!port_ok) begin
            nxt_rd_data = `UNMAPPED_DATA;
        end
    end

    // ****************************************************************
    // Read data register
    // ****************************************************************
    // Data holds between reads so a slow serial shifter may sample late
    always @(posedge mclk) begin
        if (!nrst) begin
            rd_data_ff <= `READ_DATA_RST;
            rd_hit_ff  <= `HIT_RST;
        end else if (rd_en) begin
            rd_data_ff <= nxt_rd_data;
            rd_hit_ff  <= nxt_rd_hit;
        end
    end

    // ****************************************************************
    // Read answer strobe
    // ****************************************************************
    // High the cycle after each taken read; back to back reads keep it high with no gap
    always @(posedge mclk) begin
        if (!nrst) begin
            rd_valid_ff <= `VALID_RST;
        end else begin
            rd_valid_ff <= rd_en;
        end
    end

endmodule

/* testbench/adc_conv_model.sv */
// Converter model: start, done and result lanes, index kind*4+port
`timescale 1ns/1ps
module adc_conv_model (
    // Clock
    input  wire logic    mclk,
    // Conversion events
    output logic [11:0]  conv_start,
    output logic [11:0]  conv_done,
    output logic [179:0] conv_result
);
    initial begin
        conv_start = 12'h000;
        conv_done = 12'h000;
        conv_result = {180{1'b1}};
    end
    // Result is valid only with done; inverted after so stale data is not trusted
    task automatic convert(input int idx, input logic [14:0] val, input int busy);
        @(posedge mclk) #1 conv_start[idx] = 1'b1;
        @(posedge mclk) #1 conv_start[idx] = 1'b0;
        repeat (busy) @(posedge mclk);
        #1 conv_result[idx*15 +: 15] = val;
        conv_done[idx] = 1'b1;
        @(posedge mclk) #1 conv_done[idx] = 1'b0;
        conv_result[idx*15 +: 15] = ~val;
    endtask
endmodule

/* testbench/adc_result_sva.sv */
// Checker for done flag timing and read answers of the result registers
`timescale 1ns/1ps
`include "adc_result_defines.vh"
module adc_result_sva #(
    parameter NPORT  = 4,
    parameter PORT_W = 2
) (
    input wire logic                       mclk,
    input wire logic                       nrst,
    input wire logic [NPORT-1:0]           volt_start,
    input wire logic [NPORT-1:0]           volt_done,
    input wire logic [NPORT*`RESULT_W-1:0] volt_result,
    input wire logic [NPORT-1:0]           cur_start,
    input wire logic [NPORT-1:0]           cur_done,
    input wire logic [NPORT-1:0]           temp_start,
    input wire logic [NPORT-1:0]           temp_done,
    input wire logic                       rd_en,
    input wire logic [PORT_W-1:0]          rd_port,
    input wire logic [3:0]                 rd_sel,
    input wire logic [7:0]                 rd_data_ff,
    input wire logic                       rd_valid_ff,
    input wire logic                       rd_hit_ff,
    input wire logic [NPORT-1:0]           volt_ready,
    input wire logic [NPORT-1:0]           cur_ready,
    input wire logic [NPORT-1:0]           temp_ready
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    // ****************************************
    // Flag and data checks on port 0 only, select decode checks on any port; all lanes use the same slot module
    // ****************************************
    a_volt_clear: assert property (volt_start[0] && !volt_done[0] |=> !volt_ready[0])
        else $error("voltage flag not cleared at start");
    a_volt_set: assert property (volt_done[0] |=> volt_ready[0])
        else $error("voltage flag not set at end");
    a_cur_busy: assert property (cur_start[0] && !cur_done[0] ##1
        !cur_done[0] |-> !cur_ready[0])
        else $error("current flag high while busy");
    a_cur_set: assert property ($rose(cur_ready[0]) |-> $past(cur_done[0]))
        else $error("current flag rose without done");
    a_temp_clear: assert property (temp_start[0] && !temp_done[0] |=> !temp_ready[0])
        else $error("temperature flag not cleared");
    a_temp_set: assert property (temp_done[0] |=> temp_ready[0])
        else $error("temperature flag not set");
    a_flag_read: assert property (rd_en && rd_sel == 4'h9 && rd_port == 2'h0
        |=> rd_valid_ff && rd_data_ff[7] == $past(volt_ready[0]))
        else $error("voltage flag bit wrong in read");
    a_volt_low: assert property (volt_done[0] ##1 !volt_done[0] ##1
        (rd_en && rd_sel == 4'h8 && rd_port == 2'h0 && !volt_done[0])
        |=> rd_data_ff == $past(volt_result[7:0], 3))
        else $error("voltage low byte wrong");
    a_bad_sel: assert property (rd_en && (rd_sel < 4'h8 || rd_sel > 4'hD)
        |=> rd_valid_ff && !rd_hit_ff && rd_data_ff == `UNMAPPED_DATA)
        else $error("unmapped read not refused");
    a_hit_map: assert property (rd_en && rd_sel inside {[4'h8:4'hD]} |=> rd_hit_ff)
        else $error("mapped read not hit");
    c_volt: cover property (volt_done[0]);
    c_temp_rd: cover property (rd_en && rd_sel == 4'hD);
    c_bad_rd: cover property (rd_en && rd_sel < 4'h8);
endmodule

bind port_adc_result_registers adc_result_sva #(.NPORT(NPORT), .PORT_W(PORT_W)) u_sva (
    .mclk, .nrst, .volt_start, .volt_done, .volt_result, .cur_start, .cur_done,
    .temp_start, .temp_done, .rd_en, .rd_port, .rd_sel, .rd_data_ff, .rd_valid_ff,
    .rd_hit_ff, .volt_ready, .cur_ready, .temp_ready);

/* testbench/tb.sv */
// Self-checking bench for the per-port result registers
`timescale 1ns/1ps
module tb;
    logic         mclk;
    logic         nrst;
    logic         rd_en;
    logic [1:0]   rd_port;
    logic [3:0]   rd_sel;
    wire  [7:0]   rd_data_ff;
    wire          rd_valid_ff;
    wire          rd_hit_ff;
    wire  [11:0]  conv_start;
    wire  [11:0]  conv_done;
    wire  [179:0] conv_result;
    int           fail_count;
    int           tests_run;
    int           cycles = 0;
    logic [7:0]   lo;
    logic [7:0]   hi;
    logic [14:0]  v;
    wire  [3:0]   meas_active;

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    adc_conv_model u_conv (.mclk, .conv_start, .conv_done, .conv_result);

    port_adc_result_registers DUT (
        .mclk, .nrst, .rd_en, .rd_port, .rd_sel, .rd_data_ff, .rd_valid_ff, .rd_hit_ff,
        .volt_start(conv_start[3:0]), .volt_done(conv_done[3:0]),
        .volt_result(conv_result[59:0]), .cur_start(conv_start[7:4]),
        .cur_done(conv_done[7:4]), .cur_result(conv_result[119:60]),
        .temp_start(conv_start[11:8]), .temp_done(conv_done[11:8]),
        .temp_result(conv_result[179:120]),
        .volt_ready(), .cur_ready(), .temp_ready(), .meas_active(meas_active));

    // ****************************************
    // Tasks
    // ****************************************
    function automatic logic [14:0] vof(input int i);
        return 15'(32'h7F5A ^ (i * 32'h0931));
    endfunction

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rd(input logic [1:0] p, input logic [3:0] s, output logic [7:0] d);
        @(posedge mclk) #1 rd_en = 1'b1;
        rd_port = p;
        rd_sel = s;
        @(posedge mclk) #1 rd_en = 1'b0;
        d = rd_data_ff;
        check({7'h00, rd_valid_ff}, 8'h01);
        check({7'h00, rd_hit_ff}, {7'h00, s inside {[4'h8:4'hD]}});
    endtask

    task automatic final_report();
        $display("%0d compares, %0d mismatches", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Ceiling well above the roughly 250 cycles the tests take
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fail_count++;
            $display("wrong value at %0t: timeout", $time);
            final_report();
        end
    end

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        nrst = 1'b0;
        rd_en = 1'b0;
        rd_port = 2'h0;
        rd_sel = 4'h0;
        fail_count = 0;
        tests_run = 0;
        repeat (8) @(posedge mclk);
        #1 nrst = 1'b1;
        for (int s = 0; s < 16; s++) begin
            rd(2'(s), 4'(s), lo);
            check(lo, 8'h00);
        end
        $display("test reset values and unmapped codes done");
        for (int i = 0; i < 12; i++) begin
            v = vof(i);
            fork
                u_conv.convert(i, v, 6);
                begin
                    repeat (3) @(posedge mclk);
                    rd(2'(i % 4), 4'h9 + 4'(2 * (i / 4)), hi);
                    check({7'h00, hi[7]}, 8'h00);
                    check({4'h0, meas_active}, 8'h01 << (i % 4));
                end
            join
            check({4'h0, meas_active}, 8'h00);
            rd(2'(i % 4), 4'h8 + 4'(2 * (i / 4)), lo);
            rd(2'(i % 4), 4'h9 + 4'(2 * (i / 4)), hi);
            check(lo, v[7:0]);
            check(hi, {1'b1, v[14:8]});
        end
        $display("test conversions per port and kind done");
        // Every lane again: a write that leaked into another port or kind shows here
        for (int i = 0; i < 12; i++) begin
            v = vof(i);
            rd(2'(i % 4), 4'h8 + 4'(2 * (i / 4)), lo);
            rd(2'(i % 4), 4'h9 + 4'(2 * (i / 4)), hi);
            check(lo, v[7:0]);
            check(hi, {1'b1, v[14:8]});
        end
        $display("test lane isolation done");
        final_report();
    end
endmodule
